// ==== hw/rcl_ctrl.sv ====
// reset sequencing, reset cause, watchdog, peripheral resets and clock selection
// assumes the bus master and every request input run on aclk except the two pins
`timescale 1ns/1ps
`default_nettype none

module rcl_ctrl #(
  parameter logic [15:0] PLL_LOCK_CYCLES = rcl_pkg::PLL_LOCK_RESET
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic ext_reset_pin_n,
  input wire logic brownout_detect,
  output logic internal_reset_n,
  output logic brownout_irq,
  output logic watchdog_irq,
  output logic [2:0][31:0] periph_reset,
  output logic [rcl_pkg::VOLTAGE_ADJUST_FIELD_W-1:0] voltage_adjust,
  output rcl_pkg::rcl_clk_t clk_ctl
);
  import rcl_pkg::*;

  // ==========================================================================
  // helpers
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    case (a)
      OFF_BOR_CTL, OFF_REG_CTL, OFF_SRST0, OFF_SRST1, OFF_SRST2, OFF_CAUSE,
      OFF_RUN_CFG, OFF_PLL_XLAT, OFF_RUN_CFG_EXT, OFF_WD_LOAD, OFF_WD_CTL,
      OFF_WD_VALUE, OFF_WD_ICLR, OFF_WD_RIS, OFF_SYS_REQ, OFF_CLK_STAT: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // crystal number to {out divider, reference divider, feedback}
  function automatic logic [15:0] crystal_number_field_to_pll(input logic [4:0] x);
    logic [8:0] f;
    f = 9'(PLL_F_BASE - {4'h0, x});
    return {2'b00, x, f};
  endfunction

  // the crystal field lives only in the basic register
  function automatic rcl_run_t decode_run(input logic [31:0] basic,
                                          input logic [31:0] ext);
    rcl_run_t r;
    r.crystal_number_field = basic[RUN_CRYSTAL_NUMBER_FIELD_LSB +: 5];
    if (ext[EXT_USE_BIT]) begin
      r.oscsrc = ext[RUN_OSC_LSB +: 3];
      r.sysdiv = ext[RUN_DIV_LSB +: 4];
      r.bypass = ext[RUN_BYPASS_BIT];
      r.pwrdn = ext[RUN_PWRDN_BIT];
    end else begin
      r.oscsrc = {1'b0, basic[RUN_OSC_LSB +: 2]};
      r.sysdiv = basic[RUN_DIV_LSB +: 4];
      r.bypass = basic[RUN_BYPASS_BIT];
      r.pwrdn = basic[RUN_PWRDN_BIT];
    end
    return r;
  endfunction

  // ==========================================================================
  // bus slave: address and data may arrive in either order
  logic aw_full, w_full, wr_fire;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  assign awready = !aw_full;
  assign wready = !w_full;
  assign arready = !rvalid;
  assign wr_fire = aw_full && w_full && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_addr_q <= 12'h000;
    end else if (awvalid && awready) begin
      aw_full <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (wr_fire) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (wvalid && wready) begin
      w_full <= 1'b1;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (wr_fire) begin
      w_full <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= 2'b00;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= is_mapped(aw_addr_q) ? 2'b00 : 2'b10;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  function automatic logic wr_to(input logic [11:0] off);
    return wr_fire && (aw_addr_q == off);
  endfunction

  // ==========================================================================
  // registers written by software
  logic [31:0] bor_ctl, run_basic, run_ext, wd_load;
  logic [2:0][31:0] srst;
  logic [1:0] wd_ctl;
  logic bor_en;
  rcl_run_t eff;

  assign bor_en = bor_ctl[BOR_EN_BIT];
  assign eff = decode_run(run_basic, run_ext);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bor_ctl <= BOR_CTL_RESET;
    end else if (wr_to(OFF_BOR_CTL)) begin
      bor_ctl <= merge_strb(bor_ctl, w_data_q, w_strb_q);
    end
  end

  // field value n selects a fixed voltage step from the low end of the range
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      voltage_adjust <= REG_CTL_RESET;
    end else if (wr_to(OFF_REG_CTL) && w_strb_q[0]) begin
      voltage_adjust <= w_data_q[VOLTAGE_ADJUST_FIELD_W-1:0];
    end
  end

  // each bit drives the unit of the same index as its clock gate, in all its
  // clock domains; the unit stays reset from the set until the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      srst <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_to(OFF_SRST0 + 12'(i * 4))) begin
          srst[i] <= merge_strb(srst[i], w_data_q, w_strb_q);
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      periph_reset <= '0;
    end else begin
      periph_reset <= srst;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_basic <= RUN_CFG_RESET;
      run_ext <= RUN_CFG_EXT_RESET;
    end else begin
      if (wr_to(OFF_RUN_CFG)) begin
        run_basic <= merge_strb(run_basic, w_data_q, w_strb_q);
      end
      if (wr_to(OFF_RUN_CFG_EXT)) begin
        run_ext <= merge_strb(run_ext, w_data_q, w_strb_q);
      end
    end
  end

  // ==========================================================================
  // reset request inputs
  logic ext_meta, ext_sync_n, bor_meta, bor_sync;
  logic ext_req, bor_rst, sys_req_q, wd_rst_q, req_any;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_meta <= 1'b1;
      ext_sync_n <= 1'b1;
      bor_meta <= 1'b0;
      bor_sync <= 1'b0;
    end else begin
      ext_meta <= ext_reset_pin_n;
      ext_sync_n <= ext_meta;
      bor_meta <= brownout_detect;
      bor_sync <= bor_meta;
    end
  end

  assign ext_req = !ext_sync_n;
  assign bor_rst = bor_sync && bor_en;
  assign req_any = ext_req || bor_rst || sys_req_q || wd_rst_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      brownout_irq <= 1'b0;
    end else begin
      brownout_irq <= bor_sync && !bor_en;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_req_q <= 1'b0;
    end else begin
      sys_req_q <= wr_to(OFF_SYS_REQ) && w_strb_q[0] && w_data_q[SYS_REQ_BIT];
    end
  end

  // ==========================================================================
  // internal reset sequencer; power-on starts in the drain so release is stretched
  rcl_seq_t seq_state, next_seq;
  logic [3:0] seq_cnt;

  always_comb begin
    next_seq = seq_state;
    case (seq_state)
      SEQ_IDLE: begin
        if (req_any) begin
          next_seq = SEQ_HOLD;
        end
      end
      SEQ_HOLD: begin
        if (!req_any) begin
          next_seq = SEQ_DRAIN;
        end
      end
      SEQ_DRAIN: begin
        if (req_any) begin
          next_seq = SEQ_HOLD;
        end else if (seq_cnt == 4'h0) begin
          next_seq = SEQ_IDLE;
        end
      end
      default: next_seq = SEQ_HOLD;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_state <= SEQ_DRAIN;
      seq_cnt <= RST_STRETCH;
      internal_reset_n <= 1'b0;
    end else begin
      seq_state <= next_seq;
      internal_reset_n <= (next_seq == SEQ_IDLE);
      if (next_seq == SEQ_HOLD) begin
        seq_cnt <= RST_STRETCH;
      end else if (seq_state == SEQ_DRAIN && seq_cnt != 4'h0) begin
        seq_cnt <= seq_cnt - 4'h1;
      end
    end
  end

  // ==========================================================================
  // reset cause: set beats a clear written in the same cycle
  logic [4:0] cause, cause_set;

  assign cause_set = {sys_req_q, wd_rst_q, bor_rst, ext_req, 1'b0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause <= CAUSE_POR_VALUE;
    end else if (wr_to(OFF_CAUSE) && w_strb_q[0]) begin
      cause <= (cause & ~w_data_q[4:0]) | cause_set;
    end else begin
      cause <= cause | cause_set;
    end
  end

  // ==========================================================================
  // watchdog; the running count stops and reloads from wd_load while the system is held
  logic [31:0] wd_cnt;
  logic wd_ris, wd_clr, wd_tmo;

  assign wd_clr = (seq_state == SEQ_HOLD);
  assign wd_tmo = wd_ctl[WD_INTEN_BIT] && (wd_cnt == 32'h0000_0000);
  assign watchdog_irq = wd_ris && wd_ctl[WD_INTEN_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_load <= WD_LOAD_RESET;
      wd_ctl <= 2'b00;
    end else if (wd_clr) begin
      wd_ctl <= 2'b00;
    end else begin
      if (wr_to(OFF_WD_LOAD)) begin
        wd_load <= merge_strb(wd_load, w_data_q, w_strb_q);
      end
      if (wr_to(OFF_WD_CTL) && w_strb_q[0]) begin
        wd_ctl <= w_data_q[1:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_cnt <= WD_LOAD_RESET;
    end else if (wd_clr) begin
      wd_cnt <= wd_load;
    end else if (wr_to(OFF_WD_LOAD)) begin
      wd_cnt <= merge_strb(wd_load, w_data_q, w_strb_q);
    end else if (wd_tmo) begin
      wd_cnt <= wd_load;
    end else if (wd_ctl[WD_INTEN_BIT]) begin
      wd_cnt <= wd_cnt - 32'h0000_0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_ris <= 1'b0;
      wd_rst_q <= 1'b0;
    end else begin
      if (wd_clr) begin
        wd_ris <= 1'b0;
      end else if (wd_tmo) begin
        wd_ris <= 1'b1;
      end else if (wr_to(OFF_WD_ICLR)) begin
        wd_ris <= 1'b0;
      end
      wd_rst_q <= wd_tmo && wd_ris && wd_ctl[WD_RESEN_BIT] && !wd_clr;
    end
  end

  // ==========================================================================
  // pll translation, lock wait and clock selection
  logic [4:0] crystal_number_field_seen;
  logic [15:0] pll_cfg, lock_cnt;
  logic pwrdn_q, crystal_number_field_chg, pll_up, pll_ready;
  rcl_src_t osc_src;

  assign crystal_number_field_chg = (eff.crystal_number_field != crystal_number_field_seen);
  assign pll_up = pwrdn_q && !eff.pwrdn;
  assign pll_ready = !eff.pwrdn && (lock_cnt == 16'h0000);

  always_comb begin
    case (eff.oscsrc)
      3'h0: osc_src = SRC_MAIN;
      3'h2: osc_src = SRC_INT_DIV4;
      3'h3: osc_src = SRC_LF30;
      3'h4: osc_src = SRC_RTC;
      default: osc_src = SRC_INT;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crystal_number_field_seen <= CRYSTAL_NUMBER_FIELD_RESET;
      pll_cfg <= crystal_number_field_to_pll(CRYSTAL_NUMBER_FIELD_RESET);
      pwrdn_q <= 1'b1;
      lock_cnt <= PLL_LOCK_CYCLES;
    end else begin
      crystal_number_field_seen <= eff.crystal_number_field;
      pwrdn_q <= eff.pwrdn;
      if (crystal_number_field_chg) begin
        pll_cfg <= crystal_number_field_to_pll(eff.crystal_number_field);
      end
      if (eff.pwrdn || crystal_number_field_chg || pll_up) begin
        lock_cnt <= PLL_LOCK_CYCLES;
      end else if (lock_cnt != 16'h0000) begin
        lock_cnt <= lock_cnt - 16'h0001;
      end
    end
  end

  // pll is only handed out once locked; otherwise the raw source runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_ctl <= '{sysclk_src: SRC_INT, sysdiv: 4'h0, pll_enable: 1'b0,
                   pll_ready: 1'b0, pll_cfg: 16'h0000};
    end else begin
      clk_ctl.sysclk_src <= (!eff.bypass && pll_ready) ? SRC_PLL : osc_src;
      clk_ctl.sysdiv <= eff.sysdiv;
      clk_ctl.pll_enable <= !eff.pwrdn;
      clk_ctl.pll_ready <= pll_ready;
      clk_ctl.pll_cfg <= pll_cfg;
    end
  end

  // ==========================================================================
  // read side
  logic [31:0] rd_mux;

  always_comb begin
    case (araddr)
      OFF_BOR_CTL: rd_mux = bor_ctl;
      OFF_REG_CTL: rd_mux = {26'h0, voltage_adjust};
      OFF_SRST0: rd_mux = srst[0];
      OFF_SRST1: rd_mux = srst[1];
      OFF_SRST2: rd_mux = srst[2];
      OFF_CAUSE: rd_mux = {27'h0, cause};
      OFF_RUN_CFG: rd_mux = run_basic;
      OFF_PLL_XLAT: rd_mux = {16'h0, pll_cfg};
      OFF_RUN_CFG_EXT: rd_mux = run_ext;
      OFF_WD_LOAD: rd_mux = wd_load;
      OFF_WD_CTL: rd_mux = {30'h0, wd_ctl};
      OFF_WD_VALUE: rd_mux = wd_cnt;
      OFF_WD_RIS: rd_mux = {31'h0, wd_ris};
      OFF_CLK_STAT: rd_mux = {27'h0, pll_ready, 1'b0, clk_ctl.sysclk_src};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'b00;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rd_mux;
      rresp <= is_mapped(araddr) ? 2'b00 : 2'b10;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_held;
    !internal_reset_n;
  endsequence

  sequence s_release;
    s_held ##[1:10] internal_reset_n;
  endsequence

  bor_gate_a: assert property (
    (!bor_en && bor_sync && !ext_req && !sys_req_q && !wd_rst_q
     && seq_state == SEQ_IDLE) |=> internal_reset_n)
    else $error("brown-out reset while disabled");
  bor_hold_a: assert property ((bor_rst ##1 bor_rst) |=> s_held)
    else $error("brown-out did not hold reset");
  bor_irq_a: assert property ((bor_sync && !bor_en) |=> brownout_irq)
    else $error("brown-out interrupt missing");
  bor_cause_a: assert property (bor_rst |=> cause[CAUSE_BOR])
    else $error("brown-out cause not recorded");
  // write strobes spelled out: a function body would read post-update values here
  cause_sticky_a: assert property (
    (cause[CAUSE_WD] && !(wr_fire && aw_addr_q == OFF_CAUSE)) |=> cause[CAUSE_WD])
    else $error("cause bit lost");
  sw_reset_a: assert property (
    (sys_req_q && !ext_req && !bor_sync) ##1 (!ext_req && !bor_sync)[*2] |-> s_release)
    else $error("system reset not released");
  wd_first_a: assert property (
    (wd_tmo && !wd_ris && !wd_clr && !(wr_fire && aw_addr_q == OFF_WD_LOAD))
    |=> wd_ris && wd_cnt == $past(wd_load))
    else $error("watchdog first time-out mishandled");
  wd_reset_a: assert property (wd_rst_q |-> $past(wd_ris) && $past(wd_tmo))
    else $error("watchdog reset without pending interrupt");
  pll_same_a: assert property (
    (lock_cnt == 16'h0000 && !crystal_number_field_chg && !eff.pwrdn && !pwrdn_q) |=> lock_cnt == 16'h0000)
    else $error("pll relock without change");
  pll_xlat_a: assert property (
    crystal_number_field_chg |=> pll_cfg == crystal_number_field_to_pll($past(eff.crystal_number_field)) && lock_cnt == PLL_LOCK_CYCLES)
    else $error("pll translation not updated");
  pll_use_a: assert property ((clk_ctl.sysclk_src == SRC_PLL) |-> $past(pll_ready))
    else $error("pll selected before lock");

endmodule
`default_nettype wire

// ==== hw/rcl_pkg.sv ====
// constants, field layouts and types shared by the reset and clock control block
// assumes a 10 MHz register clock and byte addresses on a 12-bit AXI4-Lite window
package rcl_pkg;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [11:0] OFF_BOR_CTL = 12'h030;
  localparam logic [11:0] OFF_REG_CTL = 12'h034;
  localparam logic [11:0] OFF_SRST0 = 12'h040;
  localparam logic [11:0] OFF_SRST1 = 12'h044;
  localparam logic [11:0] OFF_SRST2 = 12'h048;
  localparam logic [11:0] OFF_CAUSE = 12'h05C;
  localparam logic [11:0] OFF_RUN_CFG = 12'h060;
  localparam logic [11:0] OFF_PLL_XLAT = 12'h064;
  localparam logic [11:0] OFF_RUN_CFG_EXT = 12'h070;
  localparam logic [11:0] OFF_WD_LOAD = 12'h080;
  localparam logic [11:0] OFF_WD_CTL = 12'h084;
  localparam logic [11:0] OFF_WD_VALUE = 12'h088;
  localparam logic [11:0] OFF_WD_ICLR = 12'h08C;
  localparam logic [11:0] OFF_WD_RIS = 12'h090;
  localparam logic [11:0] OFF_SYS_REQ = 12'h0A0;
  localparam logic [11:0] OFF_CLK_STAT = 12'h0A4;

  // ==========================================================================
  // field positions
  localparam int BOR_EN_BIT = 1;
  localparam int WD_INTEN_BIT = 0;
  localparam int WD_RESEN_BIT = 1;
  localparam int SYS_REQ_BIT = 0;
  localparam int CAUSE_POR = 0;
  localparam int CAUSE_EXT = 1;
  localparam int CAUSE_BOR = 2;
  localparam int CAUSE_WD = 3;
  localparam int CAUSE_SW = 4;
  localparam int RUN_OSC_LSB = 4;
  localparam int RUN_CRYSTAL_NUMBER_FIELD_LSB = 6;
  localparam int RUN_BYPASS_BIT = 11;
  localparam int RUN_PWRDN_BIT = 13;
  localparam int RUN_DIV_LSB = 23;
  localparam int EXT_USE_BIT = 31;
  localparam int VOLTAGE_ADJUST_FIELD_W = 6;

  // ==========================================================================
  // reset values
  localparam logic [31:0] BOR_CTL_RESET = 32'h0000_7FFD;
  localparam logic [VOLTAGE_ADJUST_FIELD_W-1:0] REG_CTL_RESET = 6'h00;
  localparam logic [4:0] CAUSE_POR_VALUE = 5'h01;
  // internal oscillator, bypass set, pll powered down
  localparam logic [31:0] RUN_CFG_RESET = 32'h0780_2950;
  localparam logic [31:0] RUN_CFG_EXT_RESET = 32'h0780_2810;
  localparam logic [31:0] WD_LOAD_RESET = 32'hFFFF_FFFF;
  localparam logic [4:0] CRYSTAL_NUMBER_FIELD_RESET = 5'h05;

  // ==========================================================================
  // counts of cycles
  localparam logic [15:0] PLL_LOCK_RESET = 16'h1200;
  localparam logic [3:0] RST_STRETCH = 4'h4;
  // arbitrary pll feedback base for the translation table
  localparam logic [8:0] PLL_F_BASE = 9'h190;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    SRC_MAIN = 3'h0,
    SRC_INT = 3'h1,
    SRC_INT_DIV4 = 3'h2,
    SRC_LF30 = 3'h3,
    SRC_RTC = 3'h4,
    SRC_PLL = 3'h5
  } rcl_src_t;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_HOLD = 3'b010,
    SEQ_DRAIN = 3'b100
  } rcl_seq_t;

  typedef struct packed {
    logic [2:0] oscsrc;
    logic [4:0] crystal_number_field;
    logic [3:0] sysdiv;
    logic bypass;
    logic pwrdn;
  } rcl_run_t;

  typedef struct packed {
    rcl_src_t sysclk_src;
    logic [3:0] sysdiv;
    logic pll_enable;
    logic pll_ready;
    logic [15:0] pll_cfg;
  } rcl_clk_t;

endpackage

// ==== verif/tb_rcl_ctrl.sv ====
// self-checking bench for rcl_ctrl over its AXI4-Lite port and reset pins
// assumes rcl_pkg is compiled first; the bench drives every port itself
`timescale 1ns/1ps
`default_nettype none
module tb_rcl_ctrl;
  import rcl_pkg::*;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0] r;
  } rcl_row_t;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic brownout_detect = 0, ext_reset_pin_n = 1;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, v, rdata;
  logic awready, wready, bvalid, arready, rvalid, internal_reset_n, brownout_irq, watchdog_irq;
  logic [1:0] bresp, rresp, r;
  logic [2:0][31:0] periph_reset;
  logic [5:0] voltage_adjust;
  rcl_clk_t clk_ctl;
  int fail_count = 0, samples_checked = 0, n;
  rcl_row_t rows[4] = '{
    '{OFF_REG_CTL, 32'h0000_0015, 32'h0000_0015, 2'h0},
    '{OFF_SRST1, 32'h0000_00A5, 32'h0000_00A5, 2'h0},
    '{OFF_WD_LOAD, 32'h0000_1234, 32'h0000_1234, 2'h0},
    '{12'hFFC, 32'hDEAD_BEEF, 32'h0000_0000, 2'h2}};
  always #50 aclk = ~aclk;
  rcl_ctrl #(.PLL_LOCK_CYCLES(16'h0010)) i_rcl_ctrl (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .ext_reset_pin_n(ext_reset_pin_n), .brownout_detect(brownout_detect),
    .internal_reset_n(internal_reset_n), .brownout_irq(brownout_irq),
    .watchdog_irq(watchdog_irq), .periph_reset(periph_reset),
    .voltage_adjust(voltage_adjust), .clk_ctl(clk_ctl));
  // =====
  // bus and check tasks; all are entered just after a rising edge
  task results;
    $display("fail_count %0d samples_checked %0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task tmo;
    fail_count++;
    results;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic done;
    done = 0;
    // one edge between transfers so no strobe is driven twice in a time step
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (int k = 0; k < 50 && !done; k++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid) begin
        r = bresp;
        bready <= 0;
        done = 1;
      end
    end
    if (!done) tmo;
  endtask
  task rd(input logic [11:0] a);
    logic done;
    done = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (int k = 0; k < 50 && !done; k++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid) begin
        v = rdata;
        r = rresp;
        rready <= 0;
        done = 1;
      end
    end
    if (!done) tmo;
  endtask
  // bounded wait for the internal reset to reach a level
  task wrst(input logic lv);
    for (n = 0; n < 300 && internal_reset_n !== lv; n++) @(posedge aclk);
    if (internal_reset_n !== lv) tmo;
  endtask
  // =====
  // main sequence
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    chk(32'(clk_ctl.sysclk_src), 32'(SRC_INT));
    chk(32'(clk_ctl.pll_enable), 32'h0);
    rd(OFF_BOR_CTL);
    chk(v, BOR_CTL_RESET);
    rd(OFF_CAUSE);
    chk(v, 32'(CAUSE_POR_VALUE));
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      chk(32'(r), 32'(rows[i].r));
      rd(rows[i].a);
      chk(v, rows[i].e);
      chk(32'(r), 32'(rows[i].r));
    end
    chk(32'(voltage_adjust), 32'h15);
    chk(periph_reset[1], 32'h0000_00A5);
    wr(OFF_SRST1, 32'h0);
    wr(OFF_SRST0, 32'h0000_0008);
    @(posedge aclk);
    chk(periph_reset[0], 32'h0000_0008);
    wr(OFF_SRST0, 32'h0);
    @(posedge aclk);
    chk(periph_reset[0], 32'h0);
    // brown-out with the reset path still off only interrupts
    brownout_detect <= 1;
    repeat (6) @(posedge aclk);
    chk(32'(brownout_irq), 32'h1);
    chk(32'(internal_reset_n), 32'h1);
    wr(OFF_BOR_CTL, BOR_CTL_RESET | 32'h2);
    wrst(1'b0);
    repeat (20) @(posedge aclk);
    chk(32'(internal_reset_n), 32'h0);
    brownout_detect <= 0;
    wrst(1'b1);
    rd(OFF_CAUSE);
    chk(v & 32'h5, 32'h5);
    wr(OFF_BOR_CTL, BOR_CTL_RESET);
    wr(OFF_SYS_REQ, 32'h1);
    wrst(1'b0);
    wrst(1'b1);
    rd(OFF_CAUSE);
    chk(v & 32'h15, 32'h15);
    // crystal number change and read-only translation
    wr(OFF_RUN_CFG, (RUN_CFG_RESET & ~32'h0000_07C0) | (32'h0B << RUN_CRYSTAL_NUMBER_FIELD_LSB));
    rd(OFF_PLL_XLAT);
    chk(v, {16'h0, 2'b00, 5'h0B, 9'(PLL_F_BASE - 9'h00B)});
    wr(OFF_PLL_XLAT, 32'h0);
    rd(OFF_PLL_XLAT);
    chk(v, {16'h0, 2'b00, 5'h0B, 9'(PLL_F_BASE - 9'h00B)});
    chk(32'(clk_ctl.pll_cfg), {16'h0, 2'b00, 5'h0B, 9'(PLL_F_BASE - 9'h00B)});
    // watchdog: interrupt on first zero, reset on the second
    wr(OFF_WD_LOAD, 32'd20);
    wr(OFF_WD_CTL, 32'h3);
    for (n = 0; n < 100 && watchdog_irq !== 1'b1; n++) @(posedge aclk);
    chk(32'(watchdog_irq), 32'h1);
    wrst(1'b0);
    wrst(1'b1);
    rd(OFF_CAUSE);
    chk(v & 32'h8, 32'h8);
    // pll bring-up from the main oscillator, then an extended-register override
    repeat (16) @(posedge aclk);
    wr(OFF_RUN_CFG, (RUN_CFG_RESET & ~32'h0000_2FF0) | (32'h0B << RUN_CRYSTAL_NUMBER_FIELD_LSB));
    @(posedge aclk);
    chk(32'(clk_ctl.sysclk_src), 32'(SRC_MAIN));
    chk(32'(clk_ctl.pll_enable), 32'h1);
    chk(32'(clk_ctl.pll_ready), 32'h0);
    for (n = 0; n < 40 && clk_ctl.sysclk_src !== SRC_PLL; n++) @(posedge aclk);
    chk(32'(clk_ctl.sysclk_src), 32'(SRC_PLL));
    chk(32'(clk_ctl.pll_ready), 32'h1);
    wr(OFF_RUN_CFG_EXT, (RUN_CFG_EXT_RESET & ~32'h0000_0070) | 32'h8000_0040);
    @(posedge aclk);
    chk(32'(clk_ctl.sysclk_src), 32'(SRC_RTC));
    chk(32'(clk_ctl.pll_enable), 32'h0);
    // reset pin, then a second power-on reset in mid-run
    ext_reset_pin_n <= 0;
    wrst(1'b0);
    ext_reset_pin_n <= 1;
    wrst(1'b1);
    rd(OFF_CAUSE);
    chk(v & 32'hA, 32'hA);
    aresetn <= 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    rd(OFF_CAUSE);
    chk(v, 32'(CAUSE_POR_VALUE));
    chk(32'(clk_ctl.sysclk_src), 32'(SRC_INT));
    chk(32'(clk_ctl.pll_enable), 32'h0);
    results;
  end
endmodule
`default_nettype wire
